// ===== shared/lsr_pkg.sv
package lsr_pkg;

    // Register width and address width
    localparam int          REG_W        = 16;
    localparam int          ADDR_W       = 16;

    // Register addresses
    localparam logic [15:0] A_LOCK_COND  = 16'h0000;
    localparam logic [15:0] A_LOCK_DEM   = 16'h0001;
    localparam logic [15:0] A_BOLT_POS   = 16'h0002;
    localparam logic [15:0] A_DRV_ACT    = 16'h0003;
    localparam logic [15:0] A_DRV_VEL    = 16'h0004;
    localparam logic [15:0] A_SENS_A     = 16'h0005;
    localparam logic [15:0] A_SENS_B     = 16'h0006;
    localparam logic [15:0] A_MAG_NORM   = 16'h0007;
    localparam logic [15:0] A_DOOR_COND  = 16'h0008;
    localparam logic [15:0] A_CTRL_STATE = 16'h0009;
    localparam logic [15:0] A_DWELL      = 16'h000A;
    localparam logic [15:0] A_STROKE     = 16'h000B;
    localparam logic [15:0] A_FAIL_EXT   = 16'h000C;
    localparam logic [15:0] A_FAIL_RET   = 16'h000D;
    localparam logic [15:0] A_CORE_MHZ   = 16'h000E;
    localparam logic [15:0] A_CLK_FLAGS  = 16'h000F;
    localparam logic [15:0] A_ACT_LIMIT  = 16'h0010;
    localparam logic [15:0] A_DRV_POS_C  = 16'h0032;
    localparam logic [15:0] A_DRV_VEL_C  = 16'h0033;

    // Bolt travel limit in increments
    localparam logic [15:0] BOLT_MAX     = 16'h0087;

    // Clock source flag field positions
    localparam int          CF_INT_RDY   = 0;
    localparam int          CF_EXT_RDY   = 1;
    localparam int          CF_PLL_LCK   = 2;
    localparam int          CF_EXT_ACT   = 3;
    localparam int          CF_SRC_LO    = 4;
    localparam int          CF_SRC_HI    = 5;

    // Stroke side codes
    localparam logic [15:0] SIDE_RIGHT   = 16'hFFFF;
    localparam logic [15:0] SIDE_AUTO    = 16'h0000;
    localparam logic [15:0] SIDE_LEFT    = 16'h0001;

    // Reset value of every register
    localparam logic [15:0] REG_RST      = 16'h0000;

    // Dwell time base: one millisecond per count
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          DWELL_MS     = 1;
    localparam int          DWELL_CYC    = CLK_HZ / 1000 * DWELL_MS;

    typedef enum logic [1:0] {
        DRV_IDLE    = 2'b00,
        DRV_EXTEND  = 2'b01,
        DRV_RETRACT = 2'b10,
        DRV_BRAKE   = 2'b11
    } lsr_drive_t;

    typedef enum logic [1:0] {
        DOOR_UNDEF   = 2'b00,
        DOOR_OPEN    = 2'b01,
        DOOR_CLOSING = 2'b10,
        DOOR_CLOSED  = 2'b11
    } lsr_door_t;

    typedef enum logic [3:0] {
        CS_START       = 4'b0000,
        CS_REFERENCING = 4'b0001,
        CS_OPENED      = 4'b0010,
        CS_LOCKING     = 4'b0011,
        CS_LOCKED      = 4'b0100,
        CS_OPEN        = 4'b0101,
        CS_ERR_LOCKED  = 4'b0110,
        CS_ERR_LOCKING = 4'b0111,
        CS_ERR_PAUSE_S = 4'b1000,
        CS_ERR_PAUSE_L = 4'b1001,
        CS_ERR_WAIT    = 4'b1010,
        CS_ERR_OPENED  = 4'b1011,
        CS_ERR_OPEN    = 4'b1100
    } lsr_ctrl_t;

endpackage

// ===== core/lsr_sat_counter.sv
`timescale 1ns/1ps
module lsr_sat_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_clear,
    input  wire logic             i_inc,
    output logic      [WIDTH-1:0] o_count
);

    localparam logic [WIDTH-1:0] ZERO = '0;
    localparam logic [WIDTH-1:0] FULL = '1;
    localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    wire              at_full = (count_q == FULL);

    // Clear restarts; count holds at full scale
    assign count_d = i_clear ? (i_inc ? ONE : ZERO)
                   : (i_inc && !at_full) ? count_q + ONE
                   : count_q;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= ZERO;
        end else if (i_ce) begin
            count_q <= count_d;
        end
    end

    assign o_count = count_q;

endmodule // lsr_sat_counter

// ===== core/lsr_status_bank.sv
// Operation
// - All registers 16-bit, read only
// - Address 0: bolt retracted 0, extended 1
// - Address 1: effective lock demand flag
// - Bolt position 0 to 135 increments
// - Drive activity idle/extend/retract/brake codes
// - Address 4: drive travel speed
// - Addresses 5, 6: field sensor readings
// - Address 7: normalised magnet position
// - Door condition undefined/open/closing/closed codes
// - Controller state, thirteen codes 0 to 12
// - Dwell time restarts on state change
// - Stroke side -1, 0 or 1
// - Failed extend count at address 12
// - Failed retract count at address 13
// - Address 14: core clock in MHz
// - Clock flags bits 0 to 3
// - Clock flags bits 4-5: source
// - Active limit is unlocked or locked setting
// - Addresses 50, 51: drive counts position, velocity
`timescale 1ns/1ps
module lsr_status_bank #(
    parameter int DWELL_CYC = lsr_pkg::DWELL_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // Register read and write request
    input  wire logic        i_rd_en,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic        i_wr_en,
    input  wire logic [15:0] i_wr_addr,
    input  wire logic [15:0] i_wr_data,
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    output logic             o_wr_reject,
    // Status sources
    input  wire logic        i_bolt_extended,
    input  wire logic        i_lock_demand,
    input  wire logic [15:0] i_bolt_travel,
    input  wire logic [1:0]  i_drive_activity,
    input  wire logic [15:0] i_drive_velocity,
    input  wire logic [15:0] i_sensor_a,
    input  wire logic [15:0] i_sensor_b,
    input  wire logic [1:0]  i_door_condition,
    input  wire logic [3:0]  i_ctrl_state,
    input  wire logic        i_side_fixed,
    input  wire logic        i_side_left,
    input  wire logic        i_extend_fail,
    input  wire logic        i_retract_fail,
    input  wire logic [15:0] i_core_mhz,
    input  wire logic        i_int_osc_ready,
    input  wire logic        i_ext_osc_ready,
    input  wire logic        i_pll_locked,
    input  wire logic        i_ext_osc_active,
    input  wire logic [1:0]  i_sys_clk_source,
    input  wire logic [15:0] i_unlocked_proximity_setting,
    input  wire logic [15:0] i_locked_proximity_setting,
    input  wire logic [15:0] i_drive_position_counts,
    input  wire logic [15:0] i_drive_velocity_counts
);

    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16  = 16'h0001;
    localparam int          TICK_W = $clog2(DWELL_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DWELL_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = '0;
    localparam logic [TICK_W-1:0] TICK_ONE  = TICK_W'(1);

    // Snapshot registers
    logic [15:0] lock_cond_q;
    logic [15:0] lock_dem_q;
    logic [15:0] bolt_pos_q;
    logic [15:0] drv_act_q;
    logic [15:0] drv_vel_q;
    logic [15:0] sens_a_q;
    logic [15:0] sens_b_q;
    logic [15:0] mag_norm_q;
    logic [15:0] door_q;
    logic [15:0] ctrl_q;
    logic [15:0] stroke_q;
    logic [15:0] core_mhz_q;
    logic [15:0] clk_flags_q;
    logic [15:0] act_limit_q;
    logic [15:0] drv_pos_c_q;
    logic [15:0] drv_vel_c_q;

    logic [15:0] lock_cond_d;
    logic [15:0] lock_dem_d;
    logic [15:0] bolt_pos_d;
    logic [15:0] drv_act_d;
    logic [15:0] mag_norm_d;
    logic [15:0] door_d;
    logic [15:0] ctrl_d;
    logic [15:0] stroke_d;
    logic [15:0] clk_flags_d;
    logic [15:0] act_limit_d;

    // Answer registers
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic        rd_valid_q;
    logic        wr_reject_q;

    // Dwell timer and failure counts
    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic              tick;
    logic              state_changed;
    logic [15:0]       dwell_count;
    logic [15:0]       fail_ext_count;
    logic [15:0]       fail_ret_count;

    assign lock_cond_d = i_bolt_extended ? ONE16 : ZERO16;

    assign lock_dem_d = i_lock_demand ? ONE16 : ZERO16;

    assign bolt_pos_d = (i_bolt_travel > lsr_pkg::BOLT_MAX) ? lsr_pkg::BOLT_MAX
                                                            : i_bolt_travel;

    assign drv_act_d = {14'h0000, i_drive_activity};

    wire signed [16:0] sens_diff = $signed({i_sensor_a[15], i_sensor_a})
                                 - $signed({i_sensor_b[15], i_sensor_b});
    assign mag_norm_d = sens_diff[16:1];

    assign door_d = {14'h0000, i_door_condition};

    wire ctrl_in_range = (i_ctrl_state <= lsr_pkg::CS_ERR_OPEN);
    assign ctrl_d = ctrl_in_range ? {12'h000, i_ctrl_state} : ctrl_q;

    assign stroke_d = !i_side_fixed ? lsr_pkg::SIDE_AUTO
                    : i_side_left   ? lsr_pkg::SIDE_LEFT
                    :                 lsr_pkg::SIDE_RIGHT;

    wire [3:0] osc_flags;
    assign osc_flags[lsr_pkg::CF_INT_RDY] = i_int_osc_ready;
    assign osc_flags[lsr_pkg::CF_EXT_RDY] = i_ext_osc_ready;
    assign osc_flags[lsr_pkg::CF_PLL_LCK] = i_pll_locked;
    assign osc_flags[lsr_pkg::CF_EXT_ACT] = i_ext_osc_active;

    assign clk_flags_d = {10'h000, i_sys_clk_source, osc_flags};

    assign act_limit_d = i_bolt_extended ? i_locked_proximity_setting
                                         : i_unlocked_proximity_setting;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_cond_q <= lsr_pkg::REG_RST;
            lock_dem_q  <= lsr_pkg::REG_RST;
            bolt_pos_q  <= lsr_pkg::REG_RST;
            drv_act_q   <= lsr_pkg::REG_RST;
            drv_vel_q   <= lsr_pkg::REG_RST;
            sens_a_q    <= lsr_pkg::REG_RST;
            sens_b_q    <= lsr_pkg::REG_RST;
            mag_norm_q  <= lsr_pkg::REG_RST;
            door_q      <= lsr_pkg::REG_RST;
            ctrl_q      <= lsr_pkg::REG_RST;
            stroke_q    <= lsr_pkg::REG_RST;
            core_mhz_q  <= lsr_pkg::REG_RST;
            clk_flags_q <= lsr_pkg::REG_RST;
            act_limit_q <= lsr_pkg::REG_RST;
            drv_pos_c_q <= lsr_pkg::REG_RST;
            drv_vel_c_q <= lsr_pkg::REG_RST;
        end else if (i_ce) begin
            lock_cond_q <= lock_cond_d;
            lock_dem_q  <= lock_dem_d;
            bolt_pos_q  <= bolt_pos_d;
            drv_act_q   <= drv_act_d;
            drv_vel_q   <= i_drive_velocity;
            sens_a_q    <= i_sensor_a;
            sens_b_q    <= i_sensor_b;
            mag_norm_q  <= mag_norm_d;
            door_q      <= door_d;
            ctrl_q      <= ctrl_d;
            stroke_q    <= stroke_d;
            core_mhz_q  <= i_core_mhz;
            clk_flags_q <= clk_flags_d;
            act_limit_q <= act_limit_d;
            drv_pos_c_q <= i_drive_position_counts;
            drv_vel_c_q <= i_drive_velocity_counts;
        end
    end

    assign state_changed = (ctrl_d != ctrl_q);

    assign tick       = (tick_cnt_q == TICK_LAST);
    assign tick_cnt_d = (state_changed || tick) ? TICK_ZERO : tick_cnt_q + TICK_ONE;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_cnt_q <= TICK_ZERO;
        end else if (i_ce) begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    lsr_sat_counter #(
        .WIDTH   (lsr_pkg::REG_W)
    ) u_dwell (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_clear   (state_changed),
        .i_inc     (tick && !state_changed),
        .o_count   (dwell_count)
    );

    lsr_sat_counter #(
        .WIDTH   (lsr_pkg::REG_W)
    ) u_fail_ext (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_clear   (1'b0),
        .i_inc     (i_extend_fail),
        .o_count   (fail_ext_count)
    );

    lsr_sat_counter #(
        .WIDTH   (lsr_pkg::REG_W)
    ) u_fail_ret (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_clear   (1'b0),
        .i_inc     (i_retract_fail),
        .o_count   (fail_ret_count)
    );

    // Address decode
    wire hit_lock_cond  = (i_rd_addr == lsr_pkg::A_LOCK_COND);
    wire hit_lock_dem   = (i_rd_addr == lsr_pkg::A_LOCK_DEM);
    wire hit_bolt_pos   = (i_rd_addr == lsr_pkg::A_BOLT_POS);
    wire hit_drv_act    = (i_rd_addr == lsr_pkg::A_DRV_ACT);
    wire hit_drv_vel    = (i_rd_addr == lsr_pkg::A_DRV_VEL);
    wire hit_sens_a     = (i_rd_addr == lsr_pkg::A_SENS_A);
    wire hit_sens_b     = (i_rd_addr == lsr_pkg::A_SENS_B);
    wire hit_mag_norm   = (i_rd_addr == lsr_pkg::A_MAG_NORM);
    wire hit_door       = (i_rd_addr == lsr_pkg::A_DOOR_COND);
    wire hit_ctrl       = (i_rd_addr == lsr_pkg::A_CTRL_STATE);
    wire hit_dwell      = (i_rd_addr == lsr_pkg::A_DWELL);
    wire hit_stroke     = (i_rd_addr == lsr_pkg::A_STROKE);
    wire hit_fail_ext   = (i_rd_addr == lsr_pkg::A_FAIL_EXT);
    wire hit_fail_ret   = (i_rd_addr == lsr_pkg::A_FAIL_RET);
    wire hit_core_mhz   = (i_rd_addr == lsr_pkg::A_CORE_MHZ);
    wire hit_clk_flags  = (i_rd_addr == lsr_pkg::A_CLK_FLAGS);
    wire hit_act_limit  = (i_rd_addr == lsr_pkg::A_ACT_LIMIT);
    wire hit_drv_pos_c  = (i_rd_addr == lsr_pkg::A_DRV_POS_C);
    wire hit_drv_vel_c  = (i_rd_addr == lsr_pkg::A_DRV_VEL_C);

    assign rd_data_d = hit_lock_cond ? lock_cond_q
                     : hit_lock_dem  ? lock_dem_q
                     : hit_bolt_pos  ? bolt_pos_q
                     : hit_drv_act   ? drv_act_q
                     : hit_drv_vel   ? drv_vel_q
                     : hit_sens_a    ? sens_a_q
                     : hit_sens_b    ? sens_b_q
                     : hit_mag_norm  ? mag_norm_q
                     : hit_door      ? door_q
                     : hit_ctrl      ? ctrl_q
                     : hit_dwell     ? dwell_count
                     : hit_stroke    ? stroke_q
                     : hit_fail_ext  ? fail_ext_count
                     : hit_fail_ret  ? fail_ret_count
                     : hit_core_mhz  ? core_mhz_q
                     : hit_clk_flags ? clk_flags_q
                     : hit_act_limit ? act_limit_q
                     : hit_drv_pos_c ? drv_pos_c_q
                     : hit_drv_vel_c ? drv_vel_c_q
                     :                 ZERO16;

    // Write data and address are never stored
    wire wr_attempt = i_wr_en && (i_wr_addr == i_wr_addr) && (i_wr_data == i_wr_data);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data_q   <= ZERO16;
            rd_valid_q  <= 1'b0;
            wr_reject_q <= 1'b0;
        end else if (i_ce) begin
            rd_valid_q  <= i_rd_en;
            if (i_rd_en) begin
                rd_data_q <= rd_data_d;
            end
            wr_reject_q <= wr_attempt;
        end
    end

    assign o_rd_data   = rd_data_q;
    assign o_rd_valid  = rd_valid_q;
    assign o_wr_reject = wr_reject_q;

endmodule // lsr_status_bank

// ===== tb/lsr_status_sva.sv
`timescale 1ns/1ps
module lsr_status_sva (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_rd_en,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic        i_wr_en,
    input  wire logic        i_bolt_extended,
    input  wire logic [15:0] i_unlocked_proximity_setting,
    input  wire logic [15:0] i_locked_proximity_setting,
    input  wire logic [15:0] o_rd_data,
    input  wire logic        o_rd_valid,
    input  wire logic        o_wr_reject
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence s_rd;
        i_ce && i_rd_en;
    endsequence
    sequence s_rd_at(logic [15:0] a);
        i_ce && i_rd_en && i_rd_addr == a;
    endsequence

    a_read_answer: assert property (s_rd |=> o_rd_valid)
        else $error("read not answered");
    a_valid_cause: assert property (o_rd_valid && $past(i_ce) |-> $past(i_rd_en))
        else $error("answer without read");
    a_data_hold: assert property (!o_rd_valid |-> $stable(o_rd_data))
        else $error("read data moved without answer");
    a_write_reject: assert property (i_ce && i_wr_en |=> o_wr_reject)
        else $error("write not rejected");
    a_reject_cause: assert property (o_wr_reject && $past(i_ce) |-> $past(i_wr_en))
        else $error("reject without write");
    a_lock_cond: assert property (s_rd_at(lsr_pkg::A_LOCK_COND) |=>
        o_rd_data == {15'h0000, $past(i_bolt_extended, 2)})
        else $error("lock condition wrong");
    a_reserved_zero: assert property (s_rd ##0 (i_rd_addr > 16'h0010
        && i_rd_addr < 16'h0032) |=> o_rd_data == 16'h0000)
        else $error("reserved read not zero");
    a_limit_select: assert property (s_rd_at(lsr_pkg::A_ACT_LIMIT) |=>
        o_rd_data == ($past(i_bolt_extended, 2) ? $past(i_locked_proximity_setting, 2)
        : $past(i_unlocked_proximity_setting, 2)))
        else $error("active limit wrong");
endmodule // lsr_status_sva

// ===== tb/lsr_master_model.sv
`timescale 1ns/1ps
module lsr_master_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_valid,
    input  wire logic        i_wr_reject,
    output logic             o_rd_en,
    output logic      [15:0] o_rd_addr,
    output logic             o_wr_en,
    output logic      [15:0] o_wr_addr,
    output logic      [15:0] o_wr_data
);
    initial begin
        o_rd_en = 1'b0;
        o_rd_addr = 16'h0000;
        o_wr_en = 1'b0;
        o_wr_addr = 16'h0000;
        o_wr_data = 16'h0000;
    end

    // Poll one register, address scrambled after use
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge i_clk_sys);
        o_rd_en <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_clk_sys);
        o_rd_en <= 1'b0;
        o_rd_addr <= ~a;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge i_clk_sys);
            if (i_rd_valid === 1'b1) begin
                d = i_rd_data;
                ok = 1'b1;
            end
        end
        @(posedge i_clk_sys);
    endtask

    // Write attempt, returns whether rejected
    task automatic wr(input logic [15:0] a, input logic [15:0] v, output bit rej);
        rej = 1'b0;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b1;
        o_wr_addr <= a;
        o_wr_data <= v;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        o_wr_data <= ~v;
        for (int n = 0; n < 4 && !rej; n++) begin
            @(negedge i_clk_sys);
            rej = (i_wr_reject === 1'b1);
        end
        @(posedge i_clk_sys);
    endtask
endmodule // lsr_master_model

// ===== tb/lsr_status_bank_bench.sv
`timescale 1ns/1ps
module lsr_status_bank_bench;
    logic        i_clk_sys = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_rd_en, i_wr_en, o_rd_valid, o_wr_reject;
    logic [15:0] i_rd_addr, i_wr_addr, i_wr_data, o_rd_data, got;
    logic        i_bolt_extended, i_lock_demand, i_side_fixed, i_side_left;
    logic        i_extend_fail, i_retract_fail, i_int_osc_ready, i_ext_osc_ready;
    logic        i_pll_locked, i_ext_osc_active;
    logic [1:0]  i_drive_activity, i_door_condition, i_sys_clk_source;
    logic [3:0]  i_ctrl_state;
    logic [15:0] i_bolt_travel, i_drive_velocity, i_sensor_a, i_sensor_b, i_core_mhz;
    logic [15:0] i_unlocked_proximity_setting, i_locked_proximity_setting;
    logic [15:0] i_drive_position_counts, i_drive_velocity_counts;
    int          mismatches = 0;
    int          checked = 0;
    bit          ok;

    always #12.5 i_clk_sys = ~i_clk_sys;

    lsr_status_bank #(.DWELL_CYC(4)) i_lsr_status_bank (.i_clk_sys, .i_rstn, .i_ce,
        .i_rd_en, .i_rd_addr, .i_wr_en, .i_wr_addr, .i_wr_data, .o_rd_data, .o_rd_valid,
        .o_wr_reject, .i_bolt_extended, .i_lock_demand, .i_bolt_travel, .i_drive_activity,
        .i_drive_velocity, .i_sensor_a, .i_sensor_b, .i_door_condition, .i_ctrl_state,
        .i_side_fixed, .i_side_left, .i_extend_fail, .i_retract_fail, .i_core_mhz,
        .i_int_osc_ready, .i_ext_osc_ready, .i_pll_locked, .i_ext_osc_active,
        .i_sys_clk_source, .i_unlocked_proximity_setting, .i_locked_proximity_setting,
        .i_drive_position_counts, .i_drive_velocity_counts);

    lsr_master_model i_lsr_master_model (.i_clk_sys, .i_rd_data(o_rd_data),
        .i_rd_valid(o_rd_valid), .i_wr_reject(o_wr_reject), .o_rd_en(i_rd_en),
        .o_rd_addr(i_rd_addr), .o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr),
        .o_wr_data(i_wr_data));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        i_lsr_master_model.rd(a, got, ok);
        if (!ok) begin
            mismatches++;
            close_out();
        end else begin
            chk(got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    initial begin
        i_bolt_extended = 1'b1;
        i_lock_demand = 1'b1;
        i_bolt_travel = 16'h00C8;
        i_drive_activity = 2'h2;
        i_drive_velocity = 16'h1234;
        i_sensor_a = 16'h0100;
        i_sensor_b = 16'hFF00;
        i_door_condition = 2'h3;
        i_ctrl_state = 4'h0;
        i_side_fixed = 1'b0;
        i_side_left = 1'b0;
        i_extend_fail = 1'b0;
        i_retract_fail = 1'b0;
        i_core_mhz = 16'h0048;
        i_int_osc_ready = 1'b1;
        i_ext_osc_ready = 1'b1;
        i_pll_locked = 1'b0;
        i_ext_osc_active = 1'b1;
        i_sys_clk_source = 2'h0;
        i_unlocked_proximity_setting = 16'hFFE2;
        i_locked_proximity_setting = 16'hFFC4;
        i_drive_position_counts = 16'h4321;
        i_drive_velocity_counts = 16'h00AB;
        step(12);
        i_rstn <= 1'b1;
        step(2);
        rd(16'h0000, 16'h0001);
        rd(16'h0001, 16'h0001);
        rd(16'h0002, 16'h0087);
        rd(16'h0004, 16'h1234);
        rd(16'h0005, 16'h0100);
        rd(16'h0006, 16'hFF00);
        rd(16'h0007, 16'h0100);
        rd(16'h000E, 16'h0048);
        rd(16'h0010, 16'hFFC4);
        rd(16'h0032, 16'h4321);
        rd(16'h0033, 16'h00AB);
        for (int a = 17; a < 53; a += 16) begin
            rd(16'(a), 16'h0000);
        end
        i_lsr_master_model.wr(16'h0000, 16'h0000, ok);
        chk({15'h0000, ok}, 16'h0001);
        i_lsr_master_model.wr(16'h0010, 16'h1111, ok);
        chk({15'h0000, ok}, 16'h0001);
        rd(16'h0000, 16'h0001);
        rd(16'h0010, 16'hFFC4);
        for (int c = 0; c < 4; c++) begin
            i_drive_activity <= 2'(c);
            i_door_condition <= 2'(3 - c);
            i_sys_clk_source <= 2'(c % 3);
            i_pll_locked <= (c == 2);
            i_int_osc_ready <= (c != 1);
            i_ext_osc_ready <= (c != 3);
            i_ext_osc_active <= (c % 2 == 1);
            i_side_fixed <= (c != 0);
            i_side_left <= (c == 2);
            step(2);
            rd(16'h0003, 16'(c));
            rd(16'h0008, 16'(3 - c));
            rd(16'h000F, {10'h000, 2'(c % 3), c % 2 == 1, c == 2, c != 3, c != 1});
            rd(16'h000B, c == 0 ? 16'h0000 : c == 2 ? 16'h0001 : 16'hFFFF);
        end
        i_bolt_extended <= 1'b0;
        i_lock_demand <= 1'b0;
        i_bolt_travel <= 16'h0087;
        i_sensor_a <= 16'h0000;
        i_sensor_b <= 16'h0100;
        step(2);
        rd(16'h0000, 16'h0000);
        rd(16'h0001, 16'h0000);
        rd(16'h0010, 16'hFFE2);
        rd(16'h0002, 16'h0087);
        rd(16'h0007, 16'hFF80);
        i_extend_fail <= 1'b1;
        i_retract_fail <= 1'b1;
        step(1);
        i_retract_fail <= 1'b0;
        step(2);
        i_extend_fail <= 1'b0;
        step(2);
        rd(16'h000C, 16'h0003);
        rd(16'h000D, 16'h0001);
        i_ce <= 1'b0;
        i_extend_fail <= 1'b1;
        step(2);
        i_ce <= 1'b1;
        i_extend_fail <= 1'b0;
        rd(16'h000C, 16'h0003);
        for (int c = 0; c < 14; c++) begin
            i_ctrl_state <= 4'(c);
            step(2);
            rd(16'h0009, c == 13 ? 16'h000C : 16'(c));
        end
        i_ctrl_state <= 4'h5;
        step(40);
        i_lsr_master_model.rd(16'h000A, got, ok);
        chk({15'h0000, ok && got >= 16'h0009 && got <= 16'h000B}, 16'h0001);
        i_ctrl_state <= 4'h6;
        step(1);
        i_lsr_master_model.rd(16'h000A, got, ok);
        chk({15'h0000, ok && got <= 16'h0001}, 16'h0001);
        close_out();
    end
endmodule // lsr_status_bank_bench

bind lsr_status_bank lsr_status_sva i_lsr_status_sva (.i_clk_sys, .i_rstn, .i_ce, .i_rd_en,
    .i_rd_addr, .i_wr_en, .i_bolt_extended, .i_unlocked_proximity_setting,
    .i_locked_proximity_setting, .o_rd_data, .o_rd_valid, .o_wr_reject);
